// *** src/pva_alarm_logic.v ***
// Per-channel scaling, sensor error substitution and process value alarms.
//
// Operation
// - Raised high limit keeps active alarm until value below new limit minus hysteresis.
// - Lowered low limit keeps active alarm until value above new limit plus hysteresis.
// - High alarm condition when scaled value exceeds high set value.
// - Low alarm condition when scaled value is below low set value.
// - Limits accepted in any order; each alarm uses only its comparison.
// - Alarm turns on only after condition held for whole ON delay.
// - Range maximum below minimum gives linear negative-gain scaling.
// - Alarms use scaled process value, never raw input.
// - Disconnection with high selection stores range maximum.
// - Disconnection with low selection stores range minimum.
// - Conversion data held at zero during restart.
`include "pva_defines.vh"
module pva_alarm_logic #(
  parameter DW   = `PVA_DATA_W,
  parameter RW   = `PVA_RAW_W,
  parameter DLYW = `PVA_DLY_W,
  parameter [RW-1:0] RAW_FULL = `PVA_RAW_FULL
) (
  // Clocking
  input  wire            sys_clk,
  input  wire            rst,
  input  wire            clkEn,
  // Conversion input
  input  wire            convDone,
  input  wire [RW-1:0]   rawValue,
  input  wire            sensorOpen,
  input  wire            unitRestart,
  // Configuration
  input  wire [DW-1:0]   rangeMax,
  input  wire [DW-1:0]   rangeMin,
  input  wire            errSelHigh,
  input  wire [DW-1:0]   highSet,
  input  wire [DW-1:0]   lowSet,
  input  wire [DW-1:0]   hysteresis,
  input  wire [DLYW-1:0] onDelay,
  // Results
  output reg  [DW-1:0]   procValue,
  output reg             valueValid,
  output wire            highAlarm,
  output wire            lowAlarm
);
  // Signed span; a reversed range gives a negative span and negative gain.
  wire signed [DW:0]      span   = $signed({rangeMax[DW-1], rangeMax})
                                   - $signed({rangeMin[DW-1], rangeMin});
  wire signed [RW+1:0]    rawS   = $signed({2'b00, rawValue});
  wire signed [DW+RW+2:0] prod   = span * rawS;
  wire signed [DW+RW+2:0] quot   = prod / $signed({3'b000, RAW_FULL});
  wire signed [DW+RW+2:0] scaled = quot + $signed({{(RW+3){rangeMin[DW-1]}}, rangeMin});
  // Capture sequencer states; the evaluation cycle follows every captured value, the clear state follows a restart.
  localparam [1:0] SEQ_IDLE  = 2'b00;
  localparam [1:0] SEQ_EVAL  = 2'b01;
  localparam [1:0] SEQ_CLEAR = 2'b10;
  reg  [DW-1:0]           capValue;
  reg  [DW-1:0]           next_procValue;
  reg                     next_valueValid;
  reg  [1:0]              seqState;
  reg  [1:0]              next_seqState;
  reg                     evalStrobe;
  // The divider is combinational; a real build would pipeline it if timing fails.
  always @* begin
    if (sensorOpen) begin
      capValue = errSelHigh ? rangeMax : rangeMin;
    end else begin
      capValue = scaled[DW-1:0];
    end
  end
  // Restart wins over a conversion in the same cycle, so no stale value survives it.
  always @* begin
    next_seqState   = SEQ_IDLE;
    next_procValue  = procValue;
    next_valueValid = valueValid;
    if (unitRestart) begin
      next_seqState   = SEQ_CLEAR;
      next_procValue  = `PVA_ZERO_DATA;
      next_valueValid = 1'b0;
    end else if (convDone) begin
      next_seqState   = SEQ_EVAL;
      next_procValue  = capValue;
      next_valueValid = 1'b1;
    end
  end
  // The strobe is decoded from the state so that it lasts exactly one enabled cycle.
  always @* begin
    case (seqState)
      SEQ_EVAL: begin
        evalStrobe = 1'b1;
      end
      SEQ_CLEAR: begin
        evalStrobe = 1'b0;
      end
      default: begin
        evalStrobe = 1'b0;
      end
    endcase
  end
  always @(posedge sys_clk) begin
    if (rst) begin
      procValue  <= `PVA_ZERO_DATA;
      valueValid <= 1'b0;
      seqState   <= SEQ_IDLE;
    end else if (clkEn) begin
      procValue  <= next_procValue;
      valueValid <= next_valueValid;
      seqState   <= next_seqState;
    end
  end
  pva_channel_alarm #(.DW(DW), .DLYW(DLYW), .HIGH(1)) highUnit (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .clkEn      (clkEn),
    .clrState   (unitRestart),
    .evalStrobe (evalStrobe),
    .procValue  (procValue),
    .setValue   (highSet),
    .hysteresis (hysteresis),
    .onDelay    (onDelay),
    .alarmOut   (highAlarm)
  );
  pva_channel_alarm #(.DW(DW), .DLYW(DLYW), .HIGH(0)) lowUnit (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .clkEn      (clkEn),
    .clrState   (unitRestart),
    .evalStrobe (evalStrobe),
    .procValue  (procValue),
    .setValue   (lowSet),
    .hysteresis (hysteresis),
    .onDelay    (onDelay),
    .alarmOut   (lowAlarm)
  );
endmodule

// *** src/pva_defines.vh ***
// Constants of the process value alarm logic.
`ifndef PVA_DEFINES_VH
`define PVA_DEFINES_VH
`define PVA_DATA_W       16
`define PVA_RAW_W        16
`define PVA_RAW_FULL     16'h0FA0
`define PVA_DLY_W        16
`define PVA_ZERO_DATA    16'h0000
`define PVA_CH_W         2
`endif

// *** src/pva_channel_alarm.v ***
// One alarm comparator with hysteresis and alarm-ON delay.
`include "pva_defines.vh"
module pva_channel_alarm #(
  parameter DW   = `PVA_DATA_W,
  parameter DLYW = `PVA_DLY_W,
  parameter HIGH = 1
) (
  // Clocking
  input  wire            sys_clk,
  input  wire            rst,
  input  wire            clkEn,
  input  wire            clrState,
  // Evaluation
  input  wire            evalStrobe,
  input  wire [DW-1:0]   procValue,
  input  wire [DW-1:0]   setValue,
  input  wire [DW-1:0]   hysteresis,
  input  wire [DLYW-1:0] onDelay,
  // Result
  output reg             alarmOut
);
  wire signed [DW+1:0] pv   = {{2{procValue[DW-1]}}, procValue};
  wire signed [DW+1:0] sv   = {{2{setValue[DW-1]}}, setValue};
  wire signed [DW+1:0] hy   = {2'b00, hysteresis};
  reg  [DLYW-1:0]      delayCnt;
  reg                  condOn;
  // The limit compared here is always the current set value, so a moved limit
  // also takes effect through the release point below.
  always @* begin
    if (HIGH != 0) begin
      condOn = alarmOut ? !(pv < sv - hy) : (pv > sv);
    end else begin
      condOn = alarmOut ? !(pv > sv + hy) : (pv < sv);
    end
  end
  always @(posedge sys_clk) begin
    if (rst || (clkEn && clrState)) begin
      alarmOut <= 1'b0;
      delayCnt <= {DLYW{1'b0}};
    end else if (clkEn && evalStrobe) begin
      if (!condOn) begin
        alarmOut <= 1'b0;
        delayCnt <= {DLYW{1'b0}};
      end else if (!alarmOut) begin
        if (delayCnt >= onDelay) begin
          alarmOut <= 1'b1;
        end else begin
          delayCnt <= delayCnt + 1'b1;
        end
      end
    end
  end
endmodule

// *** verif/pva_checker.sv ***
// Port assertions for the process value alarm logic.
module pva_checker (
  input logic sys_clk, rst, clkEn, convDone, sensorOpen, unitRestart, errSelHigh,
  input logic [15:0] rawValue, rangeMax, rangeMin, highSet, lowSet, hysteresis,
  input logic [15:0] onDelay, procValue,
  input logic valueValid, highAlarm, lowAlarm
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire tk = clkEn & convDone & ~unitRestart;
  wire signed [17:0] pv = $signed(procValue);
  // Widened so that a large hysteresis cannot wrap the limit.
  wire signed [17:0] hm = $signed(highSet) - $signed({1'b0, hysteresis});
  wire signed [17:0] lm = $signed(lowSet) + $signed({1'b0, hysteresis});
  sequence ev;
    tk ##1 (clkEn & ~unitRestart);
  endsequence
  a_restart_clear: assert property (unitRestart & clkEn |=>
    {procValue, valueValid, highAlarm, lowAlarm} == 0) else $error("restart kept state");
  a_take_valid: assert property (tk |=> valueValid) else $error("no valid");
  a_err_max: assert property (tk & sensorOpen & errSelHigh |=>
    procValue == $past(rangeMax)) else $error("open not max");
  a_err_min: assert property (tk & sensorOpen & ~errSelHigh |=>
    procValue == $past(rangeMin)) else $error("open not min");
  a_scale_min: assert property (tk & ~sensorOpen & rawValue == 0 |=>
    procValue == $past(rangeMin)) else $error("bad scale");
  a_high_on: assert property (ev ##0 (pv > $signed(highSet) && onDelay == 0) |=>
    highAlarm) else $error("high not on");
  a_low_on: assert property (ev ##0 (pv < $signed(lowSet) && onDelay == 0) |=>
    lowAlarm) else $error("low not on");
  a_high_off: assert property (ev ##0 (pv < hm) |=> !highAlarm) else $error("high on");
  a_low_off: assert property (ev ##0 (pv > lm) |=> !lowAlarm) else $error("low on");
  a_freeze_hold: assert property (!clkEn |=>
    $stable({procValue, valueValid, highAlarm, lowAlarm})) else $error("moved while frozen");
endmodule
bind pva_alarm_logic pva_checker chk (.*);

// *** verif/pva_host_model.sv ***
// Controller model that reads back the stored process value.
module pva_host_model (
  input logic        sys_clk,
  input logic [15:0] procValue,
  output logic [15:0] seenValue
);
  always @(posedge sys_clk) seenValue <= procValue;
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the process value alarm logic.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst = 1, clkEn = 1, convDone = 0, sensorOpen = 0;
  logic unitRestart = 0, errSelHigh = 0, valueValid, highAlarm, lowAlarm;
  logic [15:0] rawValue = 0, rangeMax = 0, rangeMin = 16'h0FA0, highSet = 0, lowSet = 0;
  logic [15:0] hysteresis = 16'h0064, onDelay = 0, procValue, seenValue;
  int fail_count = 0, comparisons = 0, cycles = 0;
  // Reversed range ends give negative gain; columns are raw, high, low, alarms.
  logic [15:0] t [8][4] = '{'{16'h0000,16'h0BB8,16'h0064,16'h0002},
    '{16'h03E8,16'h01F4,16'h0DAC,16'h0003}, '{16'h01F4,16'h0BB8,16'h0064,16'h0002},
    '{16'h01F4,16'h0DDE,16'h0064,16'h0002}, '{16'h0227,16'h0DDE,16'h0064,16'h0000},
    '{16'h0E10,16'h0DDE,16'h01F4,16'h0001}, '{16'h0DE8,16'h0DDE,16'h015E,16'h0001},
    '{16'h0DDD,16'h0DDE,16'h015E,16'h0000}};
  always #5 sys_clk = ~sys_clk;
  pva_alarm_logic uut (.*);
  pva_host_model host (.*);
  task chk(input logic [18:0] g, e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task conv(input logic [15:0] r);
    @(posedge sys_clk) begin
      convDone <= 1;
      rawValue <= r;
    end
    @(posedge sys_clk) convDone <= 0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task conclude;
    $display("fail_count %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 500) begin
      fail_count++;
      conclude;
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk) #1 chk({valueValid, highAlarm, lowAlarm, procValue}, 0);
    foreach (t[i]) begin
      @(posedge sys_clk) begin
        highSet <= t[i][1];
        lowSet <= t[i][2];
      end
      conv(t[i][0]);
      chk(seenValue, 16'h0FA0 - t[i][0]);
      chk({highAlarm, lowAlarm}, t[i][3]);
    end
    @(posedge sys_clk) begin
      highSet <= 16'h0BB8;
      onDelay <= 16'h0002;
    end
    for (int i = 0; i < 6; i++) begin
      conv(i == 2 ? 16'h0DAC : 16'h0000);
      chk(highAlarm, i == 5);
    end
    for (int j = 0; j < 2; j++) begin
      @(posedge sys_clk) begin
        errSelHigh <= ~j[0];
        sensorOpen <= 1;
        onDelay <= 0;
      end
      conv(16'h0123);
      chk(procValue, j ? 16'h0FA0 : 16'h0000);
    end
    @(posedge sys_clk) begin
      clkEn <= 0;
      sensorOpen <= 0;
    end
    conv(16'h07D0);
    chk(procValue, 16'h0FA0);
    @(posedge sys_clk) clkEn <= 1;
    @(posedge sys_clk) unitRestart <= 1;
    @(posedge sys_clk) #1 chk({valueValid, highAlarm, lowAlarm, procValue}, 0);
    conclude;
  end
endmodule
